// [inc/fpec_consts.svh]
// Field positions, register numbers, view masks and reset values.
`ifndef FPEC_CONSTS_SVH
`define FPEC_CONSTS_SVH

// ----------------------------------------------------------------------
// Field positions inside the control and status word
// ----------------------------------------------------------------------
`define FPEC_CAUSE_HI 16
`define FPEC_CAUSE_LO 12
`define FPEC_EN_HI 11
`define FPEC_EN_LO 7
`define FPEC_FLAG_HI 6
`define FPEC_FLAG_LO 2
`define FPEC_RND_HI 1
`define FPEC_RND_LO 0

// ----------------------------------------------------------------------
// Control register numbers of the coprocessor
// ----------------------------------------------------------------------
`define FPEC_SEL_CSR 5'h1F
`define FPEC_SEL_CAUSE_VIEW 5'h1A
`define FPEC_SEL_MODE_VIEW 5'h1C

// ----------------------------------------------------------------------
// Bits reached through each view
// ----------------------------------------------------------------------
`define FPEC_MASK_CSR 32'h0001FFFF
`define FPEC_MASK_CAUSE_VIEW 32'h0001F07C
`define FPEC_MASK_MODE_VIEW 32'h00000F83
`define FPEC_MASK_NONE 32'h00000000

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FPEC_RST_CAUSE 5'h00
`define FPEC_RST_EN 5'h00
`define FPEC_RST_FLAG 5'h00
`define FPEC_RST_RND 2'h0
`define FPEC_RST_ONEHOT 4'h1

`endif

// [inc/fpec_pkg.sv]
// Types shared by the floating-point exception control logic.
package fpec_pkg;

   typedef enum logic [1:0] {
      FPEC_RND_NEAREST = 2'b00,
      FPEC_RND_ZERO = 2'b01,
      FPEC_RND_PLUS_INF = 2'b10,
      FPEC_RND_MINUS_INF = 2'b11
   } fpec_rnd_t;

   typedef enum logic [1:0] {
      FPEC_VIEW_NONE = 2'b00,
      FPEC_VIEW_CSR = 2'b01,
      FPEC_VIEW_CAUSE = 2'b10,
      FPEC_VIEW_MODE = 2'b11
   } fpec_view_t;

endpackage

// [inc/fpec_trap_if.sv]
// Interface between the register logic and the trap evaluator.
`timescale 1ns/100ps
interface fpec_trap_if;
   logic event_s;
   logic [4:0] cause;
   logic [4:0] enable;
   logic trap;
   logic [4:0] trap_bits;

   modport src (
      output event_s,
      output cause,
      output enable,
      input trap,
      input trap_bits
   );

   modport eval (
      input event_s,
      input cause,
      input enable,
      output trap,
      output trap_bits
   );
endinterface

// [hdl/fpec_trap_eval.sv]
// Trap evaluator: raises a one-cycle trap when a completion or a register write leaves an enabled cause set.
`timescale 1ns/100ps
module fpec_trap_eval (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   fpec_trap_if.eval tif
);

   logic trap_r;
   logic [4:0] trap_bits_r;
   logic [4:0] hit;

   assign hit = tif.cause & tif.enable;

   // ----------------------------------------------------------------------
   // Trap pulse and the pairs that caused it
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         trap_r <= 1'b0;
         trap_bits_r <= 5'h00;
      end else if (ce_i) begin
         trap_r <= tif.event_s && (hit != 5'h00); // [RL3] [RL4]
         trap_bits_r <= tif.event_s ? hit : 5'h00;
      end
   end

   assign tif.trap = trap_r;
   assign tif.trap_bits = trap_bits_r;

endmodule // fpec_trap_eval

// [hdl/fpec_top.sv]
// Floating-point exception control and status register with trap logic.
//
// Overview of operation
// RL1: Five cause bits sit at 16 down to 12: invalid, divide-by-zero, overflow, underflow, inexact.
// RL2: Five trap-enable bits sit at 11 down to 7 in the same order as the causes.
// RL3: A trap is taken when an arithmetic result sets a cause whose enable is set.
// RL4: A trap is also taken when a software move leaves an enabled cause set.
// RL5: Five sticky flags at 6 down to 2 collect exceptions until software clears them.
// RL6: Bits 1-0 pick rounding: nearest, toward zero, toward plus or minus infinity.
// RL7: The register answers as control register 31 of the coprocessor.
// RL8: Each completed instruction sets the flags of its causes, leaving the rest alone.
`timescale 1ns/100ps
`include "fpec_consts.svh"
module fpec_top (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic op_done_i,
   input wire logic [4:0] op_cause_i,
   input wire logic ctl_wr_i,
   input wire logic ctl_rd_i,
   input wire logic [4:0] ctl_sel_i,
   input wire logic [31:0] ctl_wdata_i,
   output logic [31:0] ctl_rdata_o,
   output logic ctl_rvalid_o,
   output logic ctl_miss_o,
   output logic [1:0] rounding_select_o,
   output logic [3:0] round_onehot_o,
   output logic [4:0] trap_enable_field_o,
   output logic [4:0] cause_o,
   output logic [4:0] flags_o,
   output logic trap_o,
   output logic [4:0] trap_cause_o
);

   // ----------------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------------
   function automatic fpec_pkg::fpec_view_t view_of(input logic [4:0] sel);
      case (sel)
         `FPEC_SEL_CSR: view_of = fpec_pkg::FPEC_VIEW_CSR; // [RL7]
         `FPEC_SEL_CAUSE_VIEW: view_of = fpec_pkg::FPEC_VIEW_CAUSE;
         `FPEC_SEL_MODE_VIEW: view_of = fpec_pkg::FPEC_VIEW_MODE;
         default: view_of = fpec_pkg::FPEC_VIEW_NONE;
      endcase
   endfunction

   function automatic logic [31:0] view_mask(
      input fpec_pkg::fpec_view_t v
   );
      case (v)
         fpec_pkg::FPEC_VIEW_CSR: view_mask = `FPEC_MASK_CSR;
         fpec_pkg::FPEC_VIEW_CAUSE: view_mask = `FPEC_MASK_CAUSE_VIEW;
         fpec_pkg::FPEC_VIEW_MODE: view_mask = `FPEC_MASK_MODE_VIEW;
         default: view_mask = `FPEC_MASK_NONE;
      endcase
   endfunction

   function automatic logic [31:0] pack_csr(
      input logic [4:0] cause,
      input logic [4:0] enable,
      input logic [4:0] flags,
      input logic [1:0] rnd
   );
      pack_csr = {15'h0000, cause, enable, flags, rnd};
   endfunction

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   fpec_trap_if tif();

   logic [4:0] cause_r;
   logic [4:0] cause_nxt;
   logic [4:0] enable_r;
   logic [4:0] enable_nxt;
   logic [4:0] flags_r;
   logic [4:0] flags_nxt;
   fpec_pkg::fpec_rnd_t rnd_r;
   fpec_pkg::fpec_rnd_t rnd_nxt;
   logic [3:0] onehot_r;
   logic [3:0] onehot_nxt;
   logic [31:0] ctl_rdata_r;
   logic ctl_rvalid_r;
   logic ctl_miss_r;
   fpec_pkg::fpec_view_t view;
   logic [31:0] mask;
   logic [31:0] image;
   logic [31:0] wr_image;
   logic wr_hit;
   logic rd_hit;

   // ----------------------------------------------------------------------
   // Access decode and write merge
   // ----------------------------------------------------------------------
   assign view = view_of(ctl_sel_i);
   assign mask = view_mask(view);
   assign wr_hit = ctl_wr_i && (view != fpec_pkg::FPEC_VIEW_NONE);
   assign rd_hit = ctl_rd_i && (view != fpec_pkg::FPEC_VIEW_NONE);
   assign image = pack_csr(cause_r, enable_r, flags_r, rnd_r);
   assign wr_image = (image & ~mask) | (ctl_wdata_i & mask);

   // ----------------------------------------------------------------------
   // Next values of the fields
   // ----------------------------------------------------------------------
   always_comb begin
      cause_nxt = cause_r;
      if (wr_hit) begin
         cause_nxt = wr_image[`FPEC_CAUSE_HI:`FPEC_CAUSE_LO]; // [RL1] [RL4]
      end
      if (op_done_i) begin
         cause_nxt = op_cause_i | // [RL1] [RL3]
            (wr_hit ? wr_image[`FPEC_CAUSE_HI:`FPEC_CAUSE_LO] : 5'h00);
      end
   end

   always_comb begin
      enable_nxt = enable_r;
      if (wr_hit) begin
         enable_nxt = wr_image[`FPEC_EN_HI:`FPEC_EN_LO]; // [RL2]
      end
   end

   always_comb begin
      flags_nxt = flags_r;
      if (wr_hit) begin
         flags_nxt = wr_image[`FPEC_FLAG_HI:`FPEC_FLAG_LO]; // [RL5]
      end
      if (op_done_i) begin
         flags_nxt = flags_nxt | op_cause_i; // [RL5] [RL8]
      end
   end

   always_comb begin
      rnd_nxt = rnd_r;
      if (wr_hit) begin
         rnd_nxt = fpec_pkg::fpec_rnd_t'(wr_image[`FPEC_RND_HI:`FPEC_RND_LO]);
      end
   end

   // ----------------------------------------------------------------------
   // Rounding decode for the datapath
   // ----------------------------------------------------------------------
   always_comb begin
      case (rnd_nxt)
         fpec_pkg::FPEC_RND_NEAREST: onehot_nxt = 4'h1; // [RL6]
         fpec_pkg::FPEC_RND_ZERO: onehot_nxt = 4'h2; // [RL6]
         fpec_pkg::FPEC_RND_PLUS_INF: onehot_nxt = 4'h4; // [RL6]
         fpec_pkg::FPEC_RND_MINUS_INF: onehot_nxt = 4'h8; // [RL6]
         default: onehot_nxt = 4'h1;
      endcase
   end

   // ----------------------------------------------------------------------
   // Field registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         cause_r <= `FPEC_RST_CAUSE;
      end else if (ce_i) begin
         cause_r <= cause_nxt;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         enable_r <= `FPEC_RST_EN;
      end else if (ce_i) begin
         enable_r <= enable_nxt;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         flags_r <= `FPEC_RST_FLAG;
      end else if (ce_i) begin
         flags_r <= flags_nxt;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         rnd_r <= fpec_pkg::fpec_rnd_t'(`FPEC_RST_RND);
         onehot_r <= `FPEC_RST_ONEHOT;
      end else if (ce_i) begin
         rnd_r <= rnd_nxt; // [RL6]
         onehot_r <= onehot_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         ctl_rdata_r <= 32'h00000000;
         ctl_rvalid_r <= 1'b0;
         ctl_miss_r <= 1'b0;
      end else if (ce_i) begin
         ctl_rvalid_r <= ctl_rd_i;
         ctl_rdata_r <= rd_hit ? (image & mask) : 32'h00000000; // [RL7]
         ctl_miss_r <= (ctl_rd_i || ctl_wr_i) &&
            (view == fpec_pkg::FPEC_VIEW_NONE);
      end
   end

   // ----------------------------------------------------------------------
   // Trap evaluation
   // ----------------------------------------------------------------------
   assign tif.event_s = op_done_i || wr_hit; // [RL3] [RL4]
   assign tif.cause = cause_nxt;
   assign tif.enable = enable_nxt;

   fpec_trap_eval u_trap (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .tif(tif.eval)
   );

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign ctl_rdata_o = ctl_rdata_r;
   assign ctl_rvalid_o = ctl_rvalid_r;
   assign ctl_miss_o = ctl_miss_r;
   assign rounding_select_o = rnd_r;
   assign round_onehot_o = onehot_r;
   assign trap_enable_field_o = enable_r;
   assign cause_o = cause_r;
   assign flags_o = flags_r;
   assign trap_o = tif.trap;
   assign trap_cause_o = tif.trap_bits;

endmodule // fpec_top

// [bench/fpec_top_monitor.sv]
// Checker of the exception control block ports.
`timescale 1ns/100ps
`include "fpec_consts.svh"
module fpec_top_monitor (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic op_done_i,
   input wire logic [4:0] op_cause_i,
   input wire logic ctl_wr_i,
   input wire logic ctl_rd_i,
   input wire logic [4:0] ctl_sel_i,
   input wire logic [31:0] ctl_rdata_o,
   input wire logic ctl_rvalid_o,
   input wire logic ctl_miss_o,
   input wire logic [1:0] rounding_select_o,
   input wire logic [3:0] round_onehot_o,
   input wire logic [4:0] trap_enable_field_o,
   input wire logic [4:0] cause_o,
   input wire logic [4:0] flags_o,
   input wire logic trap_o,
   input wire logic [4:0] trap_cause_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   wire op_s = ce_i && op_done_i && !ctl_wr_i;
   wire hit = ctl_sel_i == `FPEC_SEL_CSR;
   wire mapped = hit || ctl_sel_i == `FPEC_SEL_CAUSE_VIEW ||
      ctl_sel_i == `FPEC_SEL_MODE_VIEW;
   wire [4:0] armed = op_cause_i & trap_enable_field_o;
   a_op_trap: assert property (op_s && armed != 5'h00 |=> trap_o)
      else $error("no trap after enabled cause");
   a_op_quiet: assert property (op_s && armed == 5'h00 |=> !trap_o)
      else $error("trap without enabled cause");
   a_cause_load: assert property
      (op_s |=> cause_o == $past(op_cause_i))
      else $error("cause field not loaded");
   a_flag_sticky: assert property
      (op_s |=> flags_o == ($past(flags_o) | $past(op_cause_i)))
      else $error("flags not accumulated");
   a_trap_pairs: assert property (trap_o |-> trap_cause_o != 5'h00 &&
      trap_cause_o == (cause_o & trap_enable_field_o))
      else $error("trap cause mismatch");
   a_read_csr: assert property (ce_i && ctl_rd_i && !ctl_wr_i && hit
      |=> ctl_rvalid_o && ctl_rdata_o == {15'h0000, $past(cause_o),
      $past(trap_enable_field_o), $past(flags_o), $past(rounding_select_o)})
      else $error("control word read wrong");
   a_round_decode: assert property
      (round_onehot_o == 4'h1 << rounding_select_o)
      else $error("rounding decode wrong");
   a_miss_map: assert property (ce_i && (ctl_rd_i || ctl_wr_i) && !mapped
      |=> ctl_miss_o && ctl_rdata_o == 32'h00000000)
      else $error("unmapped access not refused");
endmodule // fpec_top_monitor
bind fpec_top fpec_top_monitor i_fpec_top_monitor (
   .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
   .op_done_i(op_done_i), .op_cause_i(op_cause_i), .ctl_wr_i(ctl_wr_i),
   .ctl_rd_i(ctl_rd_i), .ctl_sel_i(ctl_sel_i), .ctl_rdata_o(ctl_rdata_o),
   .ctl_rvalid_o(ctl_rvalid_o), .ctl_miss_o(ctl_miss_o),
   .rounding_select_o(rounding_select_o), .round_onehot_o(round_onehot_o),
   .trap_enable_field_o(trap_enable_field_o), .cause_o(cause_o),
   .flags_o(flags_o), .trap_o(trap_o), .trap_cause_o(trap_cause_o));

// [bench/fpec_core_model.sv]
// Model of the core pipeline completing arithmetic instructions.
`timescale 1ns/100ps
module fpec_core_model (
   input wire logic ref_clk_i,
   output logic op_done_o,
   output logic [4:0] op_cause_o
);
   initial begin
      op_done_o = 1'b0;
      op_cause_o = 5'h00;
   end
   // Completes one instruction; causes are scrambled once not valid.
   task automatic complete(input logic [4:0] c);
      @(negedge ref_clk_i);
      op_done_o = 1'b1;
      op_cause_o = c;
      @(negedge ref_clk_i);
      op_done_o = 1'b0;
      op_cause_o = ~c;
   endtask
endmodule // fpec_core_model

// [bench/fpec_top_bench.sv]
// Self-checking bench of the exception control block.
`timescale 1ns/100ps
`include "fpec_consts.svh"
module fpec_top_bench;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic ce_i = 1'b1;
   logic op_done_i;
   logic [4:0] op_cause_i;
   logic ctl_wr_i = 1'b0;
   logic ctl_rd_i = 1'b0;
   logic [4:0] ctl_sel_i = 5'h00;
   logic [31:0] ctl_wdata_i = 32'h00000000;
   logic [31:0] ctl_rdata_o;
   logic [1:0] rounding_select_o;
   logic [3:0] round_onehot_o;
   logic [4:0] trap_enable_field_o, cause_o, flags_o, trap_cause_o;
   logic ctl_rvalid_o, ctl_miss_o, trap_o;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   always #2 ref_clk_i = ~ref_clk_i;
   fpec_top i_fpec_top (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
      .op_done_i(op_done_i), .op_cause_i(op_cause_i), .ctl_wr_i(ctl_wr_i),
      .ctl_rd_i(ctl_rd_i), .ctl_sel_i(ctl_sel_i), .ctl_wdata_i(ctl_wdata_i),
      .ctl_rdata_o(ctl_rdata_o), .ctl_rvalid_o(ctl_rvalid_o),
      .ctl_miss_o(ctl_miss_o), .rounding_select_o(rounding_select_o),
      .round_onehot_o(round_onehot_o), .cause_o(cause_o),
      .trap_enable_field_o(trap_enable_field_o), .flags_o(flags_o),
      .trap_o(trap_o), .trap_cause_o(trap_cause_o));
   fpec_core_model i_fpec_core_model (.ref_clk_i(ref_clk_i),
      .op_done_o(op_done_i), .op_cause_o(op_cause_i));
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [4:0] s, input logic [31:0] d);
      @(negedge ref_clk_i);
      ctl_wr_i = 1'b1;
      ctl_sel_i = s;
      ctl_wdata_i = d;
      @(negedge ref_clk_i);
      ctl_wr_i = 1'b0;
      ctl_wdata_i = ~d;
   endtask
   task automatic rd(input logic [4:0] s, input logic [31:0] e);
      @(negedge ref_clk_i);
      ctl_rd_i = 1'b1;
      ctl_sel_i = s;
      @(negedge ref_clk_i);
      ctl_rd_i = 1'b0;
      chk("rdata", e, ctl_rdata_o);
      chk("rvalid", 32'h1, {31'h0, ctl_rvalid_o});
      chk("miss", {31'h0, !(s == `FPEC_SEL_CSR ||
         s == `FPEC_SEL_CAUSE_VIEW || s == `FPEC_SEL_MODE_VIEW)},
         {31'h0, ctl_miss_o});
   endtask
   task automatic trap_is(input logic t, input logic [4:0] c);
      chk("trap", {31'h0, t}, {31'h0, trap_o});
      chk("trap_cause", {27'h0, c}, {27'h0, trap_cause_o});
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      chk("onehot", 32'h1, {28'h0, round_onehot_o});
      rd(`FPEC_SEL_CSR, 32'h00000000);
      for (int m = 0; m < 4; m++) begin
         wr(`FPEC_SEL_CSR, m);
         chk("rounding", m, {30'h0, rounding_select_o});
         chk("onehot", 32'h1 << m, {28'h0, round_onehot_o});
      end
      wr(`FPEC_SEL_MODE_VIEW, 32'hFFFFFFFF);
      trap_is(1'b0, 5'h00);
      rd(`FPEC_SEL_CSR, 32'h00000F83);
      chk("trap_enable_field", 32'h1F, {27'h0, trap_enable_field_o});
      wr(`FPEC_SEL_CAUSE_VIEW, 32'hFFFFFFFF);
      trap_is(1'b1, 5'h1F);
      rd(`FPEC_SEL_CSR, 32'h0001FFFF);
      wr(`FPEC_SEL_CSR, 32'h00000800);
      trap_is(1'b0, 5'h00);
      i_fpec_core_model.complete(5'h10);
      trap_is(1'b1, 5'h10);
      chk("flags", 32'h10, {27'h0, flags_o});
      i_fpec_core_model.complete(5'h01);
      trap_is(1'b0, 5'h00);
      chk("flags", 32'h11, {27'h0, flags_o});
      chk("cause", 32'h01, {27'h0, cause_o});
      rd(`FPEC_SEL_CSR, 32'h00001844);
      wr(`FPEC_SEL_CSR, 32'h00008400);
      trap_is(1'b1, 5'h08);
      chk("flags", 32'h0, {27'h0, flags_o});
      wr(5'h05, 32'hFFFFFFFF);
      chk("miss", 32'h1, {31'h0, ctl_miss_o});
      rd(5'h05, 32'h00000000);
      rd(`FPEC_SEL_CSR, 32'h00008400);
      ce_i = 1'b0;
      i_fpec_core_model.complete(5'h1F);
      wr(`FPEC_SEL_CSR, 32'h00000003);
      ce_i = 1'b1;
      chk("flags", 32'h0, {27'h0, flags_o});
      chk("rounding", 32'h0, {30'h0, rounding_select_o});
      rd(`FPEC_SEL_CSR, 32'h00008400);
      conclude();
   end
endmodule // fpec_top_bench
